// File: shared/mon_port_pkg.sv
// constants, limits and state encodings for the serial monitor port
package mon_port_pkg;

  // clock and serial link
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned BAUD_HZ    = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned STOP_BITS  = 1;

  // lock warm-up and reference output
  localparam longint unsigned LOCK_TIME_S = 70;
  localparam longint unsigned LOCK_CYCLES = LOCK_TIME_S * longint'(CLK_HZ);
  localparam int unsigned     REF_HZ      = 10_000_000;
  localparam logic [2:0]      REF_DIV     = 3'(CLK_HZ / REF_HZ);
  localparam logic [2:0]      REF_HIGH    = 3'h2;

  // characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_QM = 8'h3F;

  // command keyword, upper case, eight characters
  localparam int unsigned LINE_CHARS  = 8;
  localparam logic [63:0] KW_TELEMETRY = 64'h4D4F_4E49_544F_5231;

  // error codes
  localparam logic [7:0] ERR_UNKNOWN  = 8'h01;
  localparam logic [7:0] ERR_OVERFLOW = 8'h02;

  // telemetry layout
  localparam int unsigned FIELDS      = 15;
  localparam logic [3:0]  FIELD_LAST  = 4'hE;
  localparam logic [3:0]  FIELD_STAT  = 4'hE;
  localparam int unsigned STAT_LOCK_BIT = 14;
  localparam logic [15:0] STAT_UNUSED = 16'h2024;
  localparam logic [15:0] FIELD_MAX [FIELDS] = '{
    16'h0B86, 16'h0E49, 16'h1130, 16'h12C0, 16'h12C0,
    16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF,
    16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'hFFFF};

  // reply generator states
  typedef enum logic [8:0] {
    G_IDLE  = 9'h001,
    G_FETCH = 9'h002,
    G_LOAD  = 9'h004,
    G_HEX   = 9'h008,
    G_QM    = 9'h010,
    G_EH    = 9'h020,
    G_EL    = 9'h040,
    G_CR    = 9'h080,
    G_LF    = 9'h100
  } gen_state_t;

endpackage

// File: rtl/param_store.sv
// working parameter store with registered read data
`timescale 1ns/1ns
module param_store #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
    $error("param_store depth does not fit the address width");
  end

  typedef struct packed {
    logic [WIDTH-1:0] rd;
  } st_t;

  st_t              s_r;
  st_t              s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];

  always_comb begin
    s_nxt    = s_r;
    s_nxt.rd = mem[raddr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = s_r.rd;

endmodule

// File: rtl/monitor_port.sv
// serial command and telemetry port with lock indicator and reference output
// How it works
// - UART 9600 baud, 8 data, no parity, one stop
// - carriage return triggers parsing of the line
// - drop line feeds and spaces, fold case
// - replies end with carriage return then line feed
// - errors send question mark, two hex digits
// - dump sends fifteen four-digit fields then CRLF
// - every field character is an ASCII hex digit
// - fields clamped to their full-scale range
// - first field never above 0x0B86
// - second field never above 0x0E49
// - third field never above 0x1130
// - fourth field inverted coil code, max 4800
// - fifth field bias, max 0x12C0
// - seventy second light-source lock phase after reset
// - 10 MHz output runs from reset on
// - lock reached once warm-up ends and loop locks
// - lock output falls low when locked
// - parameters kept in store, readable by dump
// - status bit 14 shows lock state
// - commands ignored during parameter update
`timescale 1ns/1ns
module monitor_port #(
  parameter int unsigned     BIT_CYCLES  = mon_port_pkg::BIT_CYCLES,
  parameter longint unsigned LOCK_CYCLES = mon_port_pkg::LOCK_CYCLES
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // serial link
  input  wire logic        RXD,
  output logic             TXD,
  // lock and reference
  input  wire logic        LOOP_LOCKED,
  output logic             LOCK_N,
  output logic             CLK10_OUT,
  // parameter update from the servo side
  input  wire logic        UPDATE_BUSY,
  input  wire logic        PARAM_WE,
  input  wire logic [3:0]  PARAM_ADDR,
  input  wire logic [15:0] PARAM_WDATA,
  input  wire logic [15:0] STATUS_IN
);

  if (BIT_CYCLES < 16 || BIT_CYCLES > 65535) begin : g_chk_baud
    $error("BIT_CYCLES out of range");
  end
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 64'hFFFF_FFFF) begin : g_chk_lock
    $error("LOCK_CYCLES out of range");
  end

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
  localparam logic [31:0] LOCK_END = 32'(LOCK_CYCLES);
  localparam logic [3:0]  RX_STOP  = 4'(mon_port_pkg::DATA_BITS + 1);
  localparam logic [3:0]  TX_LAST  = 4'(mon_port_pkg::DATA_BITS + mon_port_pkg::STOP_BITS);

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  function automatic logic [15:0] field_value(input logic [3:0]  idx,
                                              input logic [15:0] raw,
                                              input logic [15:0] stat,
                                              input logic        lk);
    logic [15:0] v;
    v = raw;
    if (idx == mon_port_pkg::FIELD_STAT) begin
      v = stat & ~mon_port_pkg::STAT_UNUSED;
      v[mon_port_pkg::STAT_LOCK_BIT] = lk;
    end else if (raw > mon_port_pkg::FIELD_MAX[idx]) begin
      v = mon_port_pkg::FIELD_MAX[idx];
    end
    field_value = v;
  endfunction

  typedef struct packed {
    logic                     rx_busy;
    logic [15:0]              rx_cnt;
    logic [3:0]               rx_bit;
    logic [7:0]               rx_sh;
    logic                     tx_busy;
    logic [15:0]              tx_cnt;
    logic [3:0]               tx_bit;
    logic [9:0]               tx_sh;
    logic [1:0]               b_cnt;
    logic [7:0]               b0;
    logic [7:0]               b1;
    logic [63:0]              line;
    logic [3:0]               len;
    logic                     ovf;
    mon_port_pkg::gen_state_t gs;
    logic [3:0]               fld;
    logic [1:0]               nib;
    logic [15:0]              word;
    logic [7:0]               err;
    logic [31:0]              lock_cnt;
    logic                     locked;
    logic [2:0]               div;
    logic                     clk10;
  } st_t;

  st_t         s_r;
  st_t         s_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [15:0] rd_data;
  logic        push_v;
  logic [7:0]  push_d;
  logic        push_ok;
  logic        pop;
  logic        rx_done;
  logic [7:0]  rx_ch;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  param_store #(.WIDTH(16), .DEPTH(16), .AW(4)) u_store (
    .clk   (MCLK),
    .rst_n (rst_n),
    .we    (PARAM_WE),
    .waddr (PARAM_ADDR),
    .wdata (PARAM_WDATA),
    .raddr (s_r.fld),
    .rdata (rd_data)
  );

  always_comb begin
    s_nxt   = s_r;
    rx_done = 1'b0;
    rx_ch   = upcase(s_r.rx_sh);
    push_v  = 1'b0;
    push_d  = mon_port_pkg::CH_CR;

    // receiver, start bit checked at mid-bit
    if (!s_r.rx_busy) begin
      if (!RXD) begin
        s_nxt.rx_busy = 1'b1;
        s_nxt.rx_cnt  = BIT_HALF;
        s_nxt.rx_bit  = 4'h0;
      end
    end else if (s_r.rx_cnt != 16'h0000) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
    end else begin
      s_nxt.rx_cnt = BIT_LAST;
      if (s_r.rx_bit == 4'h0) begin
        if (RXD) begin
          s_nxt.rx_busy = 1'b0;
        end else begin
          s_nxt.rx_bit = 4'h1;
        end
      end else if (s_r.rx_bit < RX_STOP) begin
        s_nxt.rx_sh  = {RXD, s_r.rx_sh[7:1]};
        s_nxt.rx_bit = s_r.rx_bit + 4'h1;
      end else begin
        s_nxt.rx_busy = 1'b0;
        rx_done       = RXD;
      end
    end

    // line assembly and command decode
    if (rx_done) begin
      if (rx_ch == mon_port_pkg::CH_CR) begin
        if (s_r.gs == mon_port_pkg::G_IDLE && !UPDATE_BUSY) begin
          if (s_r.ovf) begin
            s_nxt.err = mon_port_pkg::ERR_OVERFLOW;
            s_nxt.gs  = mon_port_pkg::G_QM;
          end else if (s_r.len == 4'(mon_port_pkg::LINE_CHARS) &&
                       s_r.line == mon_port_pkg::KW_TELEMETRY) begin
            s_nxt.fld = 4'h0;
            s_nxt.gs  = mon_port_pkg::G_FETCH;
          end else if (s_r.len != 4'h0) begin
            s_nxt.err = mon_port_pkg::ERR_UNKNOWN;
            s_nxt.gs  = mon_port_pkg::G_QM;
          end
        end
        s_nxt.line = 64'h0;
        s_nxt.len  = 4'h0;
        s_nxt.ovf  = 1'b0;
      end else if (rx_ch == mon_port_pkg::CH_LF || rx_ch == mon_port_pkg::CH_SP) begin
        s_nxt.len = s_r.len;
      end else if (s_r.len == 4'(mon_port_pkg::LINE_CHARS)) begin
        s_nxt.ovf = 1'b1;
      end else begin
        s_nxt.line = {s_r.line[55:0], rx_ch};
        s_nxt.len  = s_r.len + 4'h1;
      end
    end

    // reply generator
    case (s_r.gs)
      mon_port_pkg::G_IDLE: begin
        push_v = 1'b0;
      end
      mon_port_pkg::G_FETCH: begin
        s_nxt.gs = mon_port_pkg::G_LOAD;
      end
      mon_port_pkg::G_LOAD: begin
        s_nxt.word = field_value(s_r.fld, rd_data, STATUS_IN, s_r.locked);
        s_nxt.nib  = 2'h3;
        s_nxt.gs   = mon_port_pkg::G_HEX;
      end
      mon_port_pkg::G_HEX: begin
        push_v = 1'b1;
        push_d = hex_char(s_r.word[15:12]);
      end
      mon_port_pkg::G_QM: begin
        push_v = 1'b1;
        push_d = mon_port_pkg::CH_QM;
      end
      mon_port_pkg::G_EH: begin
        push_v = 1'b1;
        push_d = hex_char(s_r.err[7:4]);
      end
      mon_port_pkg::G_EL: begin
        push_v = 1'b1;
        push_d = hex_char(s_r.err[3:0]);
      end
      mon_port_pkg::G_CR: begin
        push_v = 1'b1;
        push_d = mon_port_pkg::CH_CR;
      end
      mon_port_pkg::G_LF: begin
        push_v = 1'b1;
        push_d = mon_port_pkg::CH_LF;
      end
      default: begin
        s_nxt.gs = mon_port_pkg::G_IDLE;
      end
    endcase

    push_ok = push_v && (s_r.b_cnt != 2'h2);
    if (push_ok) begin
      case (s_r.gs)
        mon_port_pkg::G_HEX: begin
          s_nxt.word = {s_r.word[11:0], 4'h0};
          s_nxt.nib  = s_r.nib - 2'h1;
          if (s_r.nib == 2'h0) begin
            if (s_r.fld == mon_port_pkg::FIELD_LAST) begin
              s_nxt.gs = mon_port_pkg::G_CR;
            end else begin
              s_nxt.fld = s_r.fld + 4'h1;
              s_nxt.gs  = mon_port_pkg::G_FETCH;
            end
          end
        end
        mon_port_pkg::G_QM: begin
          s_nxt.gs = mon_port_pkg::G_EH;
        end
        mon_port_pkg::G_EH: begin
          s_nxt.gs = mon_port_pkg::G_EL;
        end
        mon_port_pkg::G_EL: begin
          s_nxt.gs = mon_port_pkg::G_CR;
        end
        mon_port_pkg::G_CR: begin
          s_nxt.gs = mon_port_pkg::G_LF;
        end
        default: begin
          s_nxt.gs = mon_port_pkg::G_IDLE;
        end
      endcase
    end

    // two-entry buffer between generator and transmitter
    pop = !s_r.tx_busy && (s_r.b_cnt != 2'h0);
    if (push_ok && pop) begin
      if (s_r.b_cnt == 2'h1) begin
        s_nxt.b0 = push_d;
      end else begin
        s_nxt.b0 = s_r.b1;
        s_nxt.b1 = push_d;
      end
    end else if (push_ok) begin
      if (s_r.b_cnt == 2'h0) begin
        s_nxt.b0 = push_d;
      end else begin
        s_nxt.b1 = push_d;
      end
      s_nxt.b_cnt = s_r.b_cnt + 2'h1;
    end else if (pop) begin
      s_nxt.b0    = s_r.b1;
      s_nxt.b_cnt = s_r.b_cnt - 2'h1;
    end

    // transmitter, start bit, eight data lsb first, stop bit
    if (pop) begin
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_sh   = {1'b1, s_r.b0, 1'b0};
      s_nxt.tx_cnt  = BIT_LAST;
      s_nxt.tx_bit  = 4'h0;
    end else if (s_r.tx_busy) begin
      if (s_r.tx_cnt != 16'h0000) begin
        s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
      end else begin
        s_nxt.tx_cnt = BIT_LAST;
        s_nxt.tx_sh  = {1'b1, s_r.tx_sh[9:1]};
        s_nxt.tx_bit = s_r.tx_bit + 4'h1;
        if (s_r.tx_bit == TX_LAST) begin
          s_nxt.tx_busy = 1'b0;
        end
      end
    end

    // warm-up timer and lock indicator
    if (s_r.lock_cnt != LOCK_END) begin
      s_nxt.lock_cnt = s_r.lock_cnt + 32'h0000_0001;
    end
    s_nxt.locked = (s_r.lock_cnt == LOCK_END) && LOOP_LOCKED;

    // reference output divider
    s_nxt.div   = (s_r.div == mon_port_pkg::REF_DIV - 3'h1) ? 3'h0 : s_r.div + 3'h1;
    s_nxt.clk10 = (s_nxt.div < mon_port_pkg::REF_HIGH);
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.tx_sh <= 10'h3FF;
      s_r.gs    <= mon_port_pkg::G_IDLE;
      s_r.div   <= mon_port_pkg::REF_DIV - 3'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign TXD       = s_r.tx_sh[0];
  assign LOCK_N    = ~s_r.locked;
  assign CLK10_OUT = s_r.clk10;

endmodule

// File: dv/monitor_port_monitor.sv
// assertion checker for the serial monitor port, bound to its top module
`timescale 1ns/1ns
module monitor_port_checker #(
  parameter int unsigned     BIT_CYCLES  = 16,
  parameter longint unsigned LOCK_CYCLES = 100
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // serial link
  input wire logic TXD,
  // lock and reference
  input wire logic LOOP_LOCKED,
  input wire logic LOCK_N,
  input wire logic CLK10_OUT
);
  logic [31:0] up_r;
  logic [31:0] tx_r;
  // time since reset release and position inside a transmitted frame
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      up_r <= '0;
      tx_r <= '0;
    end else begin
      if (up_r != '1) up_r <= up_r + 32'h1;
      if (tx_r == 10 * BIT_CYCLES - 1) tx_r <= '0;
      else if (tx_r != '0 || !TXD) tx_r <= tx_r + 32'h1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  AST_REF_START: assert property (up_r == 32'h1 |-> ##[0:8] $rose(CLK10_OUT))
    else $error("reference output not started");
  AST_REF_PERIOD: assert property ($rose(CLK10_OUT) |-> ##5 $rose(CLK10_OUT))
    else $error("reference period is not five clocks");
  AST_REF_DUTY: assert property ($rose(CLK10_OUT) |-> CLK10_OUT [*2] ##1 !CLK10_OUT)
    else $error("reference high time is not two clocks");
  AST_LOCK_WAIT: assert property (64'(up_r) < LOCK_CYCLES |-> LOCK_N)
    else $error("lock shown before warm-up ended");
  AST_LOCK_FALL: assert property (64'(up_r) >= LOCK_CYCLES + 8 && LOOP_LOCKED |-> ##1 !LOCK_N)
    else $error("lock output not low when locked");
  AST_LOCK_DROP: assert property (!LOOP_LOCKED [*3] |-> LOCK_N)
    else $error("lock output low while loop unlocked");
  AST_TX_START: assert property ($fell(TXD) && tx_r == '0 |-> !TXD [*8])
    else $error("start bit too short");
  AST_TX_STOP: assert property (tx_r == 9 * BIT_CYCLES + BIT_CYCLES / 2 |-> TXD)
    else $error("stop bit not high");
  cover property ($fell(LOCK_N));
  cover property ($rose(LOCK_N));
  cover property (tx_r == 9 * BIT_CYCLES);
endmodule
bind monitor_port monitor_port_checker #(
  .BIT_CYCLES(BIT_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)
) i_checker (
  .MCLK(MCLK), .RSTN(RSTN), .TXD(TXD), .LOOP_LOCKED(LOOP_LOCKED),
  .LOCK_N(LOCK_N), .CLK10_OUT(CLK10_OUT)
);

// File: dv/host_terminal.sv
// host terminal model: sends command lines and collects reply characters
`timescale 1ns/1ns
module host_terminal #(
  parameter int unsigned BIT_CYCLES = 16
) (
  // clock
  input  wire logic clk,
  // serial link
  output logic      line_out,
  input  wire logic line_in
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  // one frame: start bit, eight data bits lsb first, one stop bit
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= fr[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
  // every line is closed by carriage return; gap makes a slow typist
  task automatic send_line(input string s, input int gap);
    foreach (s[i]) begin
      send_char(s[i]);
      repeat (gap) @(posedge clk);
    end
    send_char(mon_port_pkg::CH_CR);
  endtask
  // receiver samples mid-bit
  always begin
    @(negedge line_in);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      sh[i] = line_in;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    rx_q.push_back(sh);
  end
endmodule

// File: dv/monitor_port_test.sv
// self-checking testbench for the serial monitor port
`timescale 1ns/1ns
module monitor_port_test;
  localparam int unsigned     BITC  = 16;
  localparam longint unsigned LOCKC = 100;
  logic        MCLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        RXD;
  logic        TXD;
  logic        LOOP_LOCKED = 1'b0;
  logic        LOCK_N;
  logic        CLK10_OUT;
  logic        UPDATE_BUSY = 1'b0;
  logic        PARAM_WE = 1'b0;
  logic [3:0]  PARAM_ADDR = 4'h0;
  logic [15:0] PARAM_WDATA = 16'h0000;
  logic [15:0] STATUS_IN = 16'hFFFF;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #10 MCLK = ~MCLK;
  monitor_port #(.BIT_CYCLES(BITC), .LOCK_CYCLES(LOCKC)) i_dut (
    .MCLK(MCLK), .RSTN(RSTN), .RXD(RXD), .TXD(TXD), .LOOP_LOCKED(LOOP_LOCKED),
    .LOCK_N(LOCK_N), .CLK10_OUT(CLK10_OUT), .UPDATE_BUSY(UPDATE_BUSY),
    .PARAM_WE(PARAM_WE), .PARAM_ADDR(PARAM_ADDR), .PARAM_WDATA(PARAM_WDATA),
    .STATUS_IN(STATUS_IN)
  );
  host_terminal #(.BIT_CYCLES(BITC)) i_host (.clk(MCLK), .line_out(RXD), .line_in(TXD));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // stored value per field: below, at and just above its ceiling
  function automatic logic [15:0] wval(input int f);
    if (f % 3 == 0) return 16'h0123 + 16'(f);
    return mon_port_pkg::FIELD_MAX[f] + 16'((f % 3 == 1) ? 1 : 0);
  endfunction
  task automatic wait_reply(input int n);
    int t;
    t = 0;
    while (i_host.rx_q.size() < n && t < 20000) begin
      @(posedge MCLK);
      t++;
    end
    repeat (300) @(posedge MCLK);
    check("reply length", 32'(i_host.rx_q.size()), 32'(n));
  endtask
  task automatic expect_line(input string s);
    wait_reply(s.len() + 2);
    foreach (s[i]) check("reply char", 32'(i_host.rx_q.pop_front()), 32'(s[i]));
    check("line end cr", 32'(i_host.rx_q.pop_front()), 32'(mon_port_pkg::CH_CR));
    check("line end lf", 32'(i_host.rx_q.pop_front()), 32'(mon_port_pkg::CH_LF));
  endtask
  task automatic quiet();
    repeat (400) @(posedge MCLK);
    check("no reply", 32'(i_host.rx_q.size()), 32'h0);
  endtask
  task automatic t_ref_lock();
    int   rises;
    logic prev;
    rises = 0;
    repeat (10) @(posedge MCLK);
    prev = CLK10_OUT;
    repeat (50) begin
      @(posedge MCLK);
      if (CLK10_OUT && !prev) rises++;
      prev = CLK10_OUT;
    end
    check("reference rises", 32'(rises), 32'hA);
    check("lock before warm-up", 32'(LOCK_N), 32'h1);
    repeat (60) @(posedge MCLK);
    check("lock after warm-up", 32'(LOCK_N), 32'h0);
  endtask
  task automatic t_load();
    for (int f = 0; f < 14; f++) begin
      @(posedge MCLK);
      PARAM_WE    <= 1'b1;
      PARAM_ADDR  <= 4'(f);
      PARAM_WDATA <= wval(f);
    end
    @(posedge MCLK);
    PARAM_WE <= 1'b0;
  endtask
  task automatic t_errors();
    i_host.send_line("xyz", 0);
    expect_line("?01");
    i_host.send_line("ABCDEFGHJK", 0);
    expect_line("?02");
    i_host.send_line("", 0);
    quiet();
  endtask
  task automatic t_busy();
    UPDATE_BUSY <= 1'b1;
    i_host.send_line("Moni Tor1", 0);
    quiet();
    UPDATE_BUSY <= 1'b0;
  endtask
  // stat_exp: input all ones, unused bits cleared, bit 14 = lock
  task automatic t_dump(input logic [15:0] stat_exp, input int gap);
    logic [15:0] v;
    logic [31:0] seen;
    i_host.send_line("mon\nitor 1", gap);
    wait_reply(62);
    for (int f = 0; f < 15; f++) begin
      v = (f == 14) ? stat_exp : wval(f);
      if (f < 14 && v > mon_port_pkg::FIELD_MAX[f]) v = mon_port_pkg::FIELD_MAX[f];
      seen = '0;
      repeat (4) seen = {seen[23:0], i_host.rx_q.pop_front()};
      check("dump field", seen, {hexc(v[15:12]), hexc(v[11:8]), hexc(v[7:4]), hexc(v[3:0])});
    end
    check("dump cr", 32'(i_host.rx_q.pop_front()), 32'(mon_port_pkg::CH_CR));
    check("dump lf", 32'(i_host.rx_q.pop_front()), 32'(mon_port_pkg::CH_LF));
  endtask
  initial begin
    repeat (6) @(posedge MCLK);
    check("idle line", 32'(TXD), 32'h1);
    check("lock in reset", 32'(LOCK_N), 32'h1);
    RSTN        <= 1'b1;
    LOOP_LOCKED <= 1'b1;
    t_ref_lock();
    t_load();
    t_errors();
    t_busy();
    t_dump(16'hDFDB, 0);
    LOOP_LOCKED <= 1'b0;
    repeat (4) @(posedge MCLK);
    check("lock dropped", 32'(LOCK_N), 32'h1);
    t_dump(16'h9FDB, 40);
    tally_and_finish();
  end
endmodule
